// ### hw/sie_pkg.sv
// Constants, modes and timing for the safety input evaluator.
package sie_pkg;
  typedef enum logic [1:0] {SIE_PHOTO, SIE_TWOHAND, SIE_NET, SIE_SENSOR} sie_mode_t;
  typedef enum logic {SIE_RST_MANUAL, SIE_RST_MONITORED} sie_rst_t;
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0] FILTER_MIN_MS = 8'h03;
  localparam logic [7:0] FILTER_MAX_MS = 8'hfa;
  localparam logic [9:0] TWOHAND_WINDOW_MS = 10'h1f4;
  localparam int TEST_PULSE_PERIOD_MS = 10;
  localparam int TEST_PULSE_WIDTH_MS = 1;
  localparam int TEST_SETTLE_MS = 1;
  localparam int NUM_TEST_OUT = 4;
  localparam int NUM_IN = 4;
endpackage : sie_pkg

// ### hw/sie_evaluator.sv
// Input evaluation block: filter, mode logic, reset handling, start-up test and test pulses.
module sie_evaluator
  import sie_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Configuration
  input wire sie_mode_t modeSel,
  input wire logic resetEnable,
  input wire sie_rst_t resetType,
  input wire logic startupTestEnable,
  input wire logic [7:0] filterMs,
  input wire logic quadContacts,
  input wire logic dualLine,
  input wire logic [NUM_TEST_OUT-1:0] testOutSelect,
  input wire logic errorOutEnable,
  // Field inputs
  input wire logic [NUM_IN-1:0] contactIn,
  input wire logic resetIn,
  // Results
  output logic [NUM_TEST_OUT-1:0] testPulseOut,
  output logic blockOut,
  output logic faultOut
);

  //////////////////////////////////////////////////////////////////////////////
  logic rstMeta_q, rstSync_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  logic rstN;
  assign rstN = rstSync_q;

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond tick.
  logic [15:0] tickCnt_q;
  logic msTick;
  assign msTick = (tickCnt_q == 16'(TICK_CYCLES_P - 1));
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      tickCnt_q <= 16'h0000;
    end else if (msTick) begin
      tickCnt_q <= 16'h0000;
    end else begin
      tickCnt_q <= tickCnt_q + 16'h0001;
    end
  end

  function automatic logic [7:0] clampFilter(input logic [7:0] ms);
    if (ms < FILTER_MIN_MS) begin
      return FILTER_MIN_MS;
    end
    if (ms > FILTER_MAX_MS) begin
      return FILTER_MAX_MS;
    end
    return ms;
  endfunction : clampFilter

  //////////////////////////////////////////////////////////////////////////////
  // Test pulses: each selected output drops briefly; while low, its line must read low.
  logic [3:0] pulseMs_q;
  logic pulseLow;
  assign pulseLow = (pulseMs_q < 4'(TEST_PULSE_WIDTH_MS + TEST_SETTLE_MS));
  // The filter rests one settle time beyond the pulse, because the line reads low a few cycles after it ends.
  logic filtFreeze;
  assign filtFreeze = (pulseMs_q < 4'(TEST_PULSE_WIDTH_MS + 2 * TEST_SETTLE_MS));
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pulseMs_q <= 4'hf;
    end else if (msTick) begin
      pulseMs_q <= (pulseMs_q >= 4'(TEST_PULSE_PERIOD_MS - 1)) ? 4'h0 : pulseMs_q + 4'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      testPulseOut <= '0;
    end else begin
      testPulseOut <= pulseLow ? ~testOutSelect : {NUM_TEST_OUT{1'b1}};
    end
  end
  logic shortFault_q;
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      shortFault_q <= 1'b0;
    end else if (msTick && pulseMs_q == 4'(TEST_PULSE_WIDTH_MS) && (|testOutSelect)) begin
      if (|(contactIn & testOutSelect)) begin
        shortFault_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Debounce: one counter per line; sampling is frozen during the test pulse window.
  logic [NUM_IN-1:0] filt_q;
  logic [7:0] stable_q [NUM_IN];
  logic [7:0] filtLen;
  assign filtLen = clampFilter(filterMs);
  logic [NUM_IN-1:0] lineMasked;
  assign lineMasked = contactIn & ~(testOutSelect & {NUM_IN{pulseLow}});
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      filt_q <= '0;
      for (int i = 0; i < NUM_IN; i++) begin
        stable_q[i] <= 8'h00;
      end
    end else if (!filtFreeze) begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (lineMasked[i] == filt_q[i]) begin
          stable_q[i] <= 8'h00;
        end else if (msTick) begin
          if (stable_q[i] + 8'h01 >= filtLen) begin
            filt_q[i] <= lineMasked[i];
            stable_q[i] <= 8'h00;
          end else begin
            stable_q[i] <= stable_q[i] + 8'h01;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Filter settling after reset.
  // The filtered levels read low before the lines have been seen, which the start-up test must not take as
  // an interruption; this counter follows the same ticks as the line counters.
  logic [7:0] settleMs_q;
  logic filtSettled;
  assign filtSettled = (settleMs_q >= filtLen);
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      settleMs_q <= 8'h00;
    end else if (msTick && !filtFreeze && !filtSettled) begin
      settleMs_q <= settleMs_q + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Two-hand evaluation.
  logic btnA, btnB, pairFault;
  always_comb begin
    if (quadContacts) begin
      btnA = filt_q[0] & ~filt_q[1];
      btnB = filt_q[2] & ~filt_q[3];
      pairFault = (filt_q[0] == filt_q[1]) | (filt_q[2] == filt_q[3]);
    end else begin
      btnA = filt_q[0];
      btnB = filt_q[1];
      pairFault = 1'b0;
    end
  end
  logic [9:0] thWin_q;
  logic thTiming_q, thArmed_q;
  logic thAny, thBoth;
  assign thAny = btnA | btnB;
  assign thBoth = btnA & btnB;
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      thWin_q <= 10'h000;
      thTiming_q <= 1'b0;
      thArmed_q <= 1'b0;
    end else if (!thAny) begin
      thWin_q <= 10'h000;
      thTiming_q <= 1'b1;
      thArmed_q <= 1'b0;
    end else if (thBoth && thTiming_q) begin
      thArmed_q <= 1'b1;
      thTiming_q <= 1'b0;
    end else if (thTiming_q && msTick) begin
      if (thWin_q + 10'h001 >= TWOHAND_WINDOW_MS) begin
        thTiming_q <= 1'b0;
      end else begin
        thWin_q <= thWin_q + 10'h001;
      end
    end
  end
  logic thActive;
  assign thActive = thArmed_q & thBoth & ~pairFault;

  //////////////////////////////////////////////////////////////////////////////
  // Raw safe condition per mode.
  logic condOk, netFault;
  assign netFault = dualLine & (filt_q[0] != filt_q[1]);
  always_comb begin
    unique case (modeSel)
      SIE_PHOTO: condOk = filt_q[0];
      SIE_SENSOR: condOk = filt_q[0];
      SIE_TWOHAND: condOk = thActive;
      SIE_NET: condOk = dualLine ? (filt_q[0] & filt_q[1]) : filt_q[0];
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset input detection.
  logic resetPrev_q, monSeen_q, resetAccept;
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      resetPrev_q <= 1'b0;
      monSeen_q <= 1'b0;
    end else begin
      resetPrev_q <= resetIn;
      if (resetIn && !resetPrev_q) begin
        monSeen_q <= 1'b1;
      end else if (!resetIn && resetPrev_q) begin
        monSeen_q <= 1'b0;
      end
    end
  end
  assign resetAccept = (resetType == SIE_RST_MANUAL) ? (resetIn & ~resetPrev_q) : (~resetIn & resetPrev_q & monSeen_q);

  //////////////////////////////////////////////////////////////////////////////
  // Start-up test and latch.
  typedef enum logic [1:0] {SIE_ST_WAIT_OFF, SIE_ST_WAIT_ON, SIE_ST_DONE} sie_st_t;
  sie_st_t stState_q;
  logic stPressed_q;
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      stState_q <= SIE_ST_WAIT_OFF;
      stPressed_q <= 1'b0;
    end else begin
      unique case (stState_q)
        SIE_ST_WAIT_OFF: begin
          if (!startupTestEnable || modeSel == SIE_NET) begin
            stState_q <= SIE_ST_DONE;
          end else if (modeSel == SIE_TWOHAND) begin
            if (thActive) begin
              stState_q <= SIE_ST_WAIT_ON;
            end
          end else if (filtSettled && !condOk) begin
            stState_q <= SIE_ST_WAIT_ON;
          end
        end
        SIE_ST_WAIT_ON: begin
          if (modeSel == SIE_TWOHAND ? !thAny : condOk) begin
            stState_q <= SIE_ST_DONE;
          end
        end
        SIE_ST_DONE: stState_q <= SIE_ST_DONE;
        default: stState_q <= SIE_ST_WAIT_OFF;
      endcase
    end
  end
  logic needsReset;
  assign needsReset = resetEnable & (modeSel == SIE_PHOTO || modeSel == SIE_SENSOR);
  logic latchOn_q;
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      latchOn_q <= 1'b0;
    end else if (!condOk) begin
      latchOn_q <= 1'b0;
    end else if (resetAccept) begin
      latchOn_q <= 1'b1;
    end
  end
  logic anyFault;
  assign anyFault = shortFault_q | (modeSel == SIE_TWOHAND & pairFault) | (modeSel == SIE_NET & netFault);
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      blockOut <= 1'b0;
      faultOut <= 1'b0;
    end else begin
      blockOut <= condOk & (stState_q == SIE_ST_DONE) & (!needsReset | latchOn_q) & ~shortFault_q;
      faultOut <= errorOutEnable & anyFault;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.
  property p_beam_off;
    @(posedge sys_clk) disable iff (!rstN)
    ((modeSel == SIE_PHOTO || modeSel == SIE_SENSOR) && !filt_q[0]) |=> !blockOut;
  endproperty
  a_beam_off: assert property (p_beam_off) else $error("Output high with beam interrupted.");
  property p_direct;
    @(posedge sys_clk) disable iff (!rstN)
    (modeSel == SIE_PHOTO && !resetEnable && stState_q == SIE_ST_DONE && !shortFault_q && $stable(modeSel))
      |=> blockOut == $past(filt_q[0]);
  endproperty
  a_direct: assert property (p_direct) else $error("Output does not follow input without reset.");
  property p_manual;
    @(posedge sys_clk) disable iff (!rstN)
    (needsReset && !latchOn_q && condOk && resetType == SIE_RST_MANUAL && resetIn && !resetPrev_q) |=> latchOn_q;
  endproperty
  a_manual: assert property (p_manual) else $error("Manual reset edge not accepted.");
  property p_monitored;
    @(posedge sys_clk) disable iff (!rstN)
    (resetType == SIE_RST_MONITORED && !latchOn_q && resetIn) |=> !latchOn_q;
  endproperty
  a_monitored: assert property (p_monitored) else $error("Monitored reset accepted before fall.");
  property p_short;
    @(posedge sys_clk) disable iff (!rstN)
    shortFault_q |=> !blockOut;
  endproperty
  a_short: assert property (p_short) else $error("Output on with a short detected.");
  property p_startup;
    @(posedge sys_clk) disable iff (!rstN)
    (stState_q != SIE_ST_DONE) |=> !blockOut;
  endproperty
  a_startup: assert property (p_startup) else $error("Output on before start-up test done.");
  property p_filter;
    @(posedge sys_clk) disable iff (!rstN)
    (filt_q[0] != $past(filt_q[0])) |-> $past(stable_q[0]) + 8'h01 >= filtLen;
  endproperty
  a_filter: assert property (p_filter) else $error("Filter changed level too early.");
  property p_fault;
    @(posedge sys_clk) disable iff (!rstN)
    faultOut |-> errorOutEnable;
  endproperty
  a_fault: assert property (p_fault) else $error("Fault output without its option.");
  property p_twohand;
    @(posedge sys_clk) disable iff (!rstN)
    (modeSel == SIE_TWOHAND && !thBoth) |=> !blockOut;
  endproperty
  a_twohand: assert property (p_twohand) else $error("Two-hand output without both buttons.");
  property p_net;
    @(posedge sys_clk) disable iff (!rstN)
    (modeSel == SIE_NET && !dualLine && stState_q == SIE_ST_DONE && !shortFault_q) |=> blockOut == $past(filt_q[0]);
  endproperty
  a_net: assert property (p_net) else $error("Network output differs from line.");
  property p_pulse_sel;
    @(posedge sys_clk) disable iff (!rstN)
    1'b1 |=> ((testPulseOut | $past(testOutSelect)) == 4'hf);
  endproperty
  a_pulse_sel: assert property (p_pulse_sel) else $error("Test pulse on an unselected output.");
  property p_cov_on;
    @(posedge sys_clk) disable iff (!rstN)
    !blockOut ##1 blockOut;
  endproperty
  c_cov_on: cover property (p_cov_on);
  property p_cov_th;
    @(posedge sys_clk) disable iff (!rstN)
    modeSel == SIE_TWOHAND && thActive;
  endproperty
  c_cov_th: cover property (p_cov_th);
  property p_cov_fault;
    @(posedge sys_clk) disable iff (!rstN)
    faultOut;
  endproperty
  c_cov_fault: cover property (p_cov_fault);
  property p_cov_pulse;
    @(posedge sys_clk) disable iff (!rstN)
    testPulseOut != 4'hf;
  endproperty
  c_cov_pulse: cover property (p_cov_pulse);

endmodule : sie_evaluator

// ### bench/sie_field_model.sv
// Field-side model of the sensors, buttons and upstream lines feeding the evaluator.
module sie_field_model (
  // Clock
  input wire logic sys_clk,
  // Bench controls
  input wire logic [3:0] fieldLevel,
  input wire logic [3:0] shortLine,
  // Evaluator side
  input wire logic [3:0] testPulseOut,
  output logic [3:0] contactIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // sensor response delay
  // Twenty-five cycles is 2.5 ms at the bench's ten-cycle millisecond, inside the allowed response band.
  localparam int RESP_CYCLES = 25;
  logic [3:0] beam_q = 4'h0;
  logic [4:0] respCnt_q = 5'h00;
  always_ff @(posedge sys_clk) begin
    if (fieldLevel == beam_q) begin
      respCnt_q <= 5'h00;
    end else if (respCnt_q == 5'(RESP_CYCLES - 1)) begin
      beam_q <= fieldLevel;
      respCnt_q <= 5'h00;
    end else begin
      respCnt_q <= respCnt_q + 5'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // pulsed contact lines
  // A tested line drops while its pulse is low.
  // A shorted line stays high, so the evaluator has something to catch.
  always_ff @(posedge sys_clk) begin
    contactIn <= shortLine | (beam_q & testPulseOut);
  end
endmodule : sie_field_model

// ### bench/safety_input_evaluator_tb.sv
// Self-checking bench for the safety input evaluator.
module safety_input_evaluator_tb
  import sie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  sie_mode_t modeSel = SIE_PHOTO;
  logic resetEnable = 1'b0;
  sie_rst_t resetType = SIE_RST_MANUAL;
  logic startupTestEnable = 1'b0;
  logic [7:0] filterMs = 8'h03;
  logic quadContacts = 1'b0;
  logic dualLine = 1'b0;
  logic [3:0] testOutSelect = 4'h0;
  logic errorOutEnable = 1'b0;
  logic resetIn = 1'b0;
  logic [3:0] fieldLevel = 4'h0;
  logic [3:0] shortLine = 4'h0;
  logic [3:0] contactIn;
  logic [3:0] testPulseOut;
  logic blockOut;
  logic faultOut;
  int miscompares = 0;
  int testsRun = 0;

  always #50 sys_clk = ~sys_clk;

  sie_field_model field (.sys_clk(sys_clk), .fieldLevel(fieldLevel), .shortLine(shortLine),
    .testPulseOut(testPulseOut), .contactIn(contactIn));
  // One millisecond is cut to ten cycles to keep the two-hand window short.
  sie_evaluator #(.TICK_CYCLES_P(10)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .modeSel(modeSel),
    .resetEnable(resetEnable), .resetType(resetType), .startupTestEnable(startupTestEnable),
    .filterMs(filterMs), .quadContacts(quadContacts), .dualLine(dualLine), .testOutSelect(testOutSelect),
    .errorOutEnable(errorOutEnable), .contactIn(contactIn), .resetIn(resetIn),
    .testPulseOut(testPulseOut), .blockOut(blockOut), .faultOut(faultOut));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (miscompares == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic check(input string what, input logic exp, input logic got);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : check

  // Waits are bounded; a missed deadline in waitFor ends the run, one in waitPulse only counts a miscompare.
  task automatic waitFor(input bit flt, input logic exp, input int maxCyc);
    int n;
    n = 0;
    while ((flt ? faultOut : blockOut) !== exp && n < maxCyc) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(flt ? "faultOut" : "blockOut", exp, flt ? faultOut : blockOut);
    if ((flt ? faultOut : blockOut) !== exp) results();
  endtask : waitFor

  task automatic holdOut(input logic exp, input int cyc);
    logic ok;
    ok = 1'b1;
    repeat (cyc) begin
      @(posedge sys_clk);
      #1;
      if (blockOut !== exp) ok = 1'b0;
    end
    check("blockOut steady", 1'b1, ok);
  endtask : holdOut

  task automatic waitPulse(input logic [3:0] exp);
    int n;
    n = 0;
    while (testPulseOut === 4'hf && n < 200) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("testPulseOut", 1'b1, testPulseOut === exp);
  endtask : waitPulse

  task automatic setLvl(input logic [3:0] v, input int gap);
    @(posedge sys_clk);
    fieldLevel <= v;
    repeat (gap) @(posedge sys_clk);
    #1;
  endtask : setLvl

  task automatic setRst(input logic v);
    @(posedge sys_clk);
    resetIn <= v;
    #1;
  endtask : setRst

  task automatic setup(input sie_mode_t m, input logic re, input sie_rst_t rt, input logic st,
    input logic [3:0] sel, input logic [3:0] lvl, input logic [2:0] opt);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    modeSel <= m;
    resetEnable <= re;
    resetType <= rt;
    startupTestEnable <= st;
    testOutSelect <= sel;
    fieldLevel <= lvl;
    filterMs <= (m == SIE_NET) ? 8'h0a : 8'h03;
    {errorOutEnable, quadContacts, dualLine} <= opt;
    shortLine <= 4'h0;
    resetIn <= 1'b0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : setup
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    setup(SIE_PHOTO, 1'b0, SIE_RST_MANUAL, 1'b0, 4'h1, 4'h0, 3'h4);
    holdOut(1'b0, 50);
    setLvl(4'h1, 0);
    holdOut(1'b0, 45);
    waitFor(1'b0, 1'b1, 300);
    check("faultOut", 1'b0, faultOut);
    waitPulse(4'he);
    holdOut(1'b1, 30);
    setLvl(4'h0, 0);
    waitFor(1'b0, 1'b0, 300);
    setLvl(4'h1, 0);
    waitFor(1'b0, 1'b1, 300);
    @(posedge sys_clk);
    shortLine <= 4'h1;
    waitFor(1'b1, 1'b1, 300);
    waitFor(1'b0, 1'b0, 10);
    setup(SIE_PHOTO, 1'b1, SIE_RST_MANUAL, 1'b0, 4'h1, 4'h1, 3'h4);
    holdOut(1'b0, 200);
    setRst(1'b1);
    waitFor(1'b0, 1'b1, 200);
    setRst(1'b0);
    setLvl(4'h0, 0);
    waitFor(1'b0, 1'b0, 300);
    setLvl(4'h1, 0);
    holdOut(1'b0, 200);
    setup(SIE_SENSOR, 1'b1, SIE_RST_MONITORED, 1'b0, 4'h0, 4'h1, 3'h4);
    holdOut(1'b0, 100);
    setRst(1'b1);
    holdOut(1'b0, 200);
    setRst(1'b0);
    waitFor(1'b0, 1'b1, 300);
    setLvl(4'h0, 0);
    waitFor(1'b0, 1'b0, 300);
    setLvl(4'h1, 0);
    holdOut(1'b0, 200);
    for (int i = 0; i < 2; i++) begin
      setup(i ? SIE_SENSOR : SIE_PHOTO, 1'b0, SIE_RST_MANUAL, 1'b1, i ? 4'h0 : 4'h1, 4'h1, 3'h4);
      holdOut(1'b0, 200);
      setLvl(4'h0, 100);
      setLvl(4'h1, 0);
      waitFor(1'b0, 1'b1, 300);
      setLvl(4'h0, 100);
      check("blockOut", 1'b0, blockOut);
      setLvl(4'h1, 0);
      waitFor(1'b0, 1'b1, 300);
    end
    setup(SIE_TWOHAND, 1'b0, SIE_RST_MANUAL, 1'b1, 4'h0, 4'h0, 3'h4);
    setLvl(4'h1, 100);
    setLvl(4'h3, 0);
    holdOut(1'b0, 200);
    setLvl(4'h0, 200);
    setLvl(4'h1, 4900);
    setLvl(4'h3, 0);
    waitFor(1'b0, 1'b1, 300);
    setLvl(4'h0, 0);
    waitFor(1'b0, 1'b0, 300);
    setLvl(4'h1, 5100);
    setLvl(4'h3, 0);
    holdOut(1'b0, 300);
    setup(SIE_TWOHAND, 1'b0, SIE_RST_MANUAL, 1'b0, 4'h0, 4'ha, 3'h6);
    setLvl(4'h9, 50);
    setLvl(4'h5, 0);
    waitFor(1'b0, 1'b1, 300);
    setLvl(4'hb, 0);
    waitFor(1'b1, 1'b1, 300);
    waitFor(1'b0, 1'b0, 10);
    setup(SIE_NET, 1'b0, SIE_RST_MANUAL, 1'b0, 4'h0, 4'h0, 3'h4);
    setLvl(4'h1, 0);
    holdOut(1'b0, 110);
    waitFor(1'b0, 1'b1, 300);
    setLvl(4'h0, 0);
    waitFor(1'b0, 1'b0, 300);
    setup(SIE_NET, 1'b0, SIE_RST_MANUAL, 1'b0, 4'h0, 4'h0, 3'h5);
    setLvl(4'h3, 0);
    waitFor(1'b0, 1'b1, 300);
    setLvl(4'h1, 0);
    waitFor(1'b1, 1'b1, 300);
    waitFor(1'b0, 1'b0, 10);
    setup(SIE_NET, 1'b0, SIE_RST_MANUAL, 1'b0, 4'h0, 4'h0, 3'h1);
    setLvl(4'h1, 300);
    check("faultOut off", 1'b0, faultOut);
    results();
  end
endmodule : safety_input_evaluator_tb
